/* pccr_config_regs.sv */
// Phase control configuration register bank with mode decoding and thermal trips
`timescale 1ns/1ps

module pccr_config_regs (
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  // Management link command layer
  input  wire logic                 cmd_valid,
  input  wire logic                 cmd_write,
  input  wire logic [7:0]           cmd_code,
  input  wire logic [15:0]          cmd_wdata,
  output logic                      cmd_ack,
  output logic                      cmd_nack,
  output logic                      cmd_rvalid,
  output logic [15:0]               cmd_rdata,
  // Device pins and core status
  input  wire logic [1:0]           power_state_input,
  input  wire logic                 enable_in,
  input  wire logic                 total_current_scale,
  input  wire logic [7:0]           temp_sensor_pin,
  input  wire logic [7:0]           temperature_input,
  input  wire logic                 fault_clear,
  // Decoded controls
  output pccr_pkg::pccr_loop_s      loop_ctrl,
  output pccr_pkg::pccr_shed_s      shed_amps,
  output logic                      low_power_active,
  output logic                      pwm_tristate,
  output logic                      soft_shutdown,
  output logic                      rc_slew_active,
  output logic                      delay_tick,
  output logic                      sensor_overheat,
  output logic                      temp_overheat,
  output logic                      thermal_alert_n
);

  // Stored register contents
  logic [15:0] main_cfg;
  logic [7:0]  aux_cfg;
  logic [15:0] shed_low;
  logic [15:0] shed_high;
  logic [7:0]  shed_hys;
  logic [15:0] sensor_cfg;
  logic [15:0] temp_cfg;

  localparam int DLY_W = pccr_pkg::DLY_CNT_W;

  // Working signals
  logic                  req_write;
  logic                  req_read;
  logic [15:0]           wmask;
  logic [15:0]           wvalue;
  logic [15:0]           read_word;
  logic [1:0]            ps_request;
  pccr_pkg::pccr_pmode_e next_mode;
  pccr_pkg::pccr_loop_s  next_loop;
  logic [DLY_W-1:0]      dly_cnt;
  logic [DLY_W-1:0]      dly_limit;
  logic [1:0]            ot_active;

  // Writable mask of a command, zero when unmapped or spare
  function automatic logic [15:0] wr_mask_of(input logic [7:0] code);
    case (code)
      pccr_pkg::CMD_MAIN_CONFIG:  wr_mask_of = pccr_pkg::MAIN_WR_MASK;
      pccr_pkg::CMD_AUX_CONFIG:   wr_mask_of = pccr_pkg::AUX_WR_MASK;
      pccr_pkg::CMD_SHED_LOW:     wr_mask_of = pccr_pkg::FULL_WR_MASK;
      pccr_pkg::CMD_SHED_HIGH:    wr_mask_of = pccr_pkg::FULL_WR_MASK;
      pccr_pkg::CMD_SHED_HYST:    wr_mask_of = pccr_pkg::BYTE_WR_MASK;
      pccr_pkg::CMD_SENSOR_THERM: wr_mask_of = pccr_pkg::FULL_WR_MASK;
      pccr_pkg::CMD_TEMP_THERM:   wr_mask_of = pccr_pkg::FULL_WR_MASK;
      default:                    wr_mask_of = pccr_pkg::ZERO_WORD;
    endcase
  endfunction : wr_mask_of

  // Whether a command code belongs to this bank
  function automatic logic is_mapped(input logic [7:0] code);
    is_mapped = (code >= pccr_pkg::CMD_TRIM_SPARE_A) && (code <= pccr_pkg::CMD_TEMP_THERM);
  endfunction : is_mapped

  // Handshake: refused while in low power or for foreign codes
  assign low_power_active = aux_cfg[pccr_pkg::AUX_LOW_PWR_BIT] && !enable_in;
  assign cmd_ack  = cmd_valid && !low_power_active && is_mapped(cmd_code);
  assign cmd_nack = cmd_valid && !cmd_ack;
  assign req_write = cmd_ack && cmd_write;
  assign req_read  = cmd_ack && !cmd_write;
  assign wmask  = wr_mask_of(cmd_code);
  assign wvalue = cmd_wdata & wmask;

  // Main config storage
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      main_cfg <= pccr_pkg::CFG_RESET;
    else if (req_write && cmd_code == pccr_pkg::CMD_MAIN_CONFIG)
      main_cfg <= wvalue;
  end

  // Aux config storage, fixed-zero bits never stored
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      aux_cfg <= pccr_pkg::CFG_RESET[7:0];
    else if (req_write && cmd_code == pccr_pkg::CMD_AUX_CONFIG)
      aux_cfg <= wvalue[7:0];
  end

  // Shedding thresholds and hysteresis storage
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shed_low  <= pccr_pkg::CFG_RESET;
      shed_high <= pccr_pkg::CFG_RESET;
      shed_hys  <= pccr_pkg::CFG_RESET[7:0];
    end
    else if (req_write)
    begin
      if (cmd_code == pccr_pkg::CMD_SHED_LOW)
        shed_low <= wvalue;
      if (cmd_code == pccr_pkg::CMD_SHED_HIGH)
        shed_high <= wvalue;
      if (cmd_code == pccr_pkg::CMD_SHED_HYST)
        shed_hys <= wvalue[7:0];
    end
  end

  // Thermal config storage
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sensor_cfg <= pccr_pkg::CFG_RESET;
      temp_cfg   <= pccr_pkg::CFG_RESET;
    end
    else if (req_write)
    begin
      if (cmd_code == pccr_pkg::CMD_SENSOR_THERM)
        sensor_cfg <= wvalue;
      if (cmd_code == pccr_pkg::CMD_TEMP_THERM)
        temp_cfg <= wvalue;
    end
  end

  // Read multiplexer
  always_comb
  begin
    case (cmd_code)
      pccr_pkg::CMD_TRIM_SPARE_A: read_word = pccr_pkg::ZERO_WORD;
      pccr_pkg::CMD_TRIM_SPARE_B: read_word = pccr_pkg::ZERO_WORD;
      pccr_pkg::CMD_MAIN_CONFIG:  read_word = main_cfg;
      pccr_pkg::CMD_AUX_CONFIG:   read_word = {8'h00, aux_cfg};
      pccr_pkg::CMD_SHED_LOW:     read_word = shed_low;
      pccr_pkg::CMD_SHED_HIGH:    read_word = shed_high;
      pccr_pkg::CMD_SHED_SPARE_A: read_word = pccr_pkg::SPARE_SHED_VAL;
      pccr_pkg::CMD_SHED_SPARE_B: read_word = pccr_pkg::SPARE_SHED_VAL;
      pccr_pkg::CMD_SHED_SPARE_C: read_word = pccr_pkg::SPARE_SHED_VAL;
      pccr_pkg::CMD_SHED_HYST:    read_word = {8'h00, shed_hys};
      pccr_pkg::CMD_SENSOR_THERM: read_word = sensor_cfg;
      pccr_pkg::CMD_TEMP_THERM:   read_word = temp_cfg;
      default:                    read_word = pccr_pkg::ZERO_WORD;
    endcase
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_rvalid <= 1'b0;
      cmd_rdata  <= pccr_pkg::ZERO_WORD;
    end
    else
    begin
      cmd_rvalid <= req_read;
      if (req_read)
        cmd_rdata <= read_word;
    end
  end

  // Power state request source and decoding
  always_comb
  begin
    if (main_cfg[pccr_pkg::MAIN_PS_SRC_BIT])
      ps_request = main_cfg[pccr_pkg::MAIN_PS_REQ_MSB:pccr_pkg::MAIN_PS_REQ_LSB];
    else
      ps_request = power_state_input;
    if (main_cfg[pccr_pkg::MAIN_APS_BIT] && main_cfg[pccr_pkg::MAIN_PS_IGN_BIT])
      next_mode = pccr_pkg::PM_FULL_CCM;
    else if (ps_request[1])
      next_mode = pccr_pkg::PM_1P_DCM;
    else if (ps_request[0])
      next_mode = pccr_pkg::PM_1P_CCM;
    else
      next_mode = pccr_pkg::PM_FULL_CCM;
  end

  // Loop controls gathered for the regulator core
  always_comb
  begin
    next_loop.dc_loop_enable_discontinuous = main_cfg[pccr_pkg::MAIN_DC_DCM_BIT];
    next_loop.dc_loop_enable_continuous    = main_cfg[pccr_pkg::MAIN_DC_CCM_BIT];
    next_loop.current_balance_enable       = main_cfg[pccr_pkg::MAIN_CB_BIT];
    next_loop.overshoot_reduce_enable      = main_cfg[pccr_pkg::MAIN_OSR_BIT];
    next_loop.phase_shedding_enable        = main_cfg[pccr_pkg::MAIN_APS_BIT];
    next_loop.voltage_from_link            = main_cfg[pccr_pkg::MAIN_VSRC_BIT];
    next_loop.phase_count                  = main_cfg[pccr_pkg::MAIN_PCNT_MSB:0];
    next_loop.phase_count_invalid          = main_cfg[pccr_pkg::MAIN_PCNT_MSB:0] > pccr_pkg::PCNT_4P;
    next_loop.power_mode                   = next_mode;
    // Single-phase DCM count is itself the deepest state
    next_loop.on_time_reduce_active        = main_cfg[pccr_pkg::MAIN_TON_RED_BIT] &&
      (next_mode == pccr_pkg::PM_1P_DCM ||
       main_cfg[pccr_pkg::MAIN_PCNT_MSB:0] == pccr_pkg::PCNT_1P_DCM);
  end

  // Registered control outputs
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      loop_ctrl <= '{power_mode: pccr_pkg::PM_FULL_CCM, default: '0};
    end
    else
      loop_ctrl <= next_loop;
  end

  // Shedding values scaled by the total_current_scale
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      shed_amps <= '0;
    else
    begin
      shed_amps.single_phase_drop_threshold  <= {1'b0, shed_low[15:8]}  << total_current_scale;
      shed_amps.discontinuous_drop_threshold <= {1'b0, shed_low[7:0]}   << total_current_scale;
      shed_amps.three_phase_drop_threshold   <= {1'b0, shed_high[15:8]} << total_current_scale;
      shed_amps.two_phase_drop_threshold     <= {1'b0, shed_high[7:0]}  << total_current_scale;
      shed_amps.shedding_hysteresis_value    <= {1'b0, shed_hys}        << total_current_scale;
    end
  end

  // Shutdown style and slew style, registered
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwm_tristate   <= 1'b0;
      soft_shutdown  <= 1'b0;
      rc_slew_active <= 1'b0;
    end
    else
    begin
      pwm_tristate   <= !enable_in && (!aux_cfg[pccr_pkg::AUX_SD_STYLE_BIT] ||
                        aux_cfg[pccr_pkg::AUX_LOW_PWR_BIT]);
      soft_shutdown  <= !enable_in && aux_cfg[pccr_pkg::AUX_SD_STYLE_BIT] &&
                        !aux_cfg[pccr_pkg::AUX_LOW_PWR_BIT];
      rc_slew_active <= aux_cfg[pccr_pkg::AUX_SLEW_BIT] && !main_cfg[pccr_pkg::MAIN_VSRC_BIT];
    end
  end

  // Delay timebase tick for turn-on and turn-off delay counters
  assign dly_limit = aux_cfg[pccr_pkg::AUX_DLY_SEL_BIT] ?
                     DLY_W'(pccr_pkg::DLY_LONG_CYC - 1) : DLY_W'(pccr_pkg::DLY_SHORT_CYC - 1);

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dly_cnt    <= '0;
      delay_tick <= 1'b0;
    end
    else if (dly_cnt >= dly_limit)
    begin
      dly_cnt    <= '0;
      delay_tick <= 1'b1;
    end
    else
    begin
      dly_cnt    <= dly_cnt + DLY_W'(1);
      delay_tick <= 1'b0;
    end
  end

  // Over-temperature protection, index 0 sensor pin, index 1 temp input
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ot
      pccr_pkg::pccr_ot_e ot_state;
      logic [7:0]         reading;
      logic [7:0]         thresh;
      logic [7:0]         hyst;
      logic               prot_en;
      logic               latch_mode;
      logic [8:0]         release_lvl;

      if (gi == 0)
      begin : g_sns
        assign reading    = temp_sensor_pin;
        assign thresh     = sensor_cfg[7:0];
        assign hyst       = {2'b00, sensor_cfg[pccr_pkg::SNS_HYS_MSB:pccr_pkg::SNS_HYS_LSB]};
        assign prot_en    = sensor_cfg[pccr_pkg::THERM_EN_BIT];
        assign latch_mode = sensor_cfg[pccr_pkg::SNS_MODE_BIT];
      end
      else
      begin : g_tmp
        assign reading    = temperature_input;
        assign thresh     = temp_cfg[15:pccr_pkg::TMP_THR_LSB];
        assign hyst       = {1'b0, temp_cfg[pccr_pkg::TMP_HYS_MSB:0]};
        assign prot_en    = 1'b1;
        assign latch_mode = temp_cfg[pccr_pkg::TMP_MODE_BIT];
      end

      // In hiccup mode, reading must fall to threshold minus hysteresis to recover; latched mode waits for fault_clear
      assign release_lvl = {1'b0, thresh} - {1'b0, hyst};

      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
          ot_state <= pccr_pkg::OT_NORMAL;
        else
        begin
          case (ot_state)
            pccr_pkg::OT_NORMAL:
              if (prot_en && reading >= thresh)
                ot_state <= latch_mode ? pccr_pkg::OT_LATCHED : pccr_pkg::OT_HICCUP;
            pccr_pkg::OT_HICCUP:
              if (!prot_en || release_lvl[8] || {1'b0, reading} <= release_lvl)
                ot_state <= pccr_pkg::OT_NORMAL;
            pccr_pkg::OT_LATCHED:
              if (fault_clear || !prot_en)
                ot_state <= pccr_pkg::OT_NORMAL;
            default:
              ot_state <= pccr_pkg::OT_NORMAL;
          endcase
        end
      end

      assign ot_active[gi] = (ot_state != pccr_pkg::OT_NORMAL);
    end
  endgenerate

  // Overheat indicators
  assign sensor_overheat = ot_active[0];
  assign temp_overheat   = ot_active[1];
  assign thermal_alert_n = !(|ot_active);

endmodule : pccr_config_regs

/* pccr_pkg.sv */
// Package for the phase control configuration register bank
package pccr_pkg;

  // Command codes on the management link
  localparam logic [7:0] CMD_TRIM_SPARE_A  = 8'hDF;
  localparam logic [7:0] CMD_TRIM_SPARE_B  = 8'hE0;
  localparam logic [7:0] CMD_MAIN_CONFIG   = 8'hE1;
  localparam logic [7:0] CMD_AUX_CONFIG    = 8'hE2;
  localparam logic [7:0] CMD_SHED_LOW      = 8'hE3;
  localparam logic [7:0] CMD_SHED_HIGH     = 8'hE4;
  localparam logic [7:0] CMD_SHED_SPARE_A  = 8'hE5;
  localparam logic [7:0] CMD_SHED_SPARE_B  = 8'hE6;
  localparam logic [7:0] CMD_SHED_SPARE_C  = 8'hE7;
  localparam logic [7:0] CMD_SHED_HYST     = 8'hE8;
  localparam logic [7:0] CMD_SENSOR_THERM  = 8'hE9;
  localparam logic [7:0] CMD_TEMP_THERM    = 8'hEA;

  // Writable bit masks, all other bits read zero except the shedding spares, which read all ones
  localparam logic [15:0] MAIN_WR_MASK   = 16'hFBF7;
  localparam logic [15:0] AUX_WR_MASK    = 16'h000F;
  localparam logic [15:0] FULL_WR_MASK   = 16'hFFFF;
  localparam logic [15:0] BYTE_WR_MASK   = 16'h00FF;
  localparam logic [15:0] SPARE_SHED_VAL = 16'hFFFF;
  localparam logic [15:0] ZERO_WORD      = 16'h0000;
  localparam logic [15:0] CFG_RESET      = 16'h0000;

  // Main config field positions
  localparam int MAIN_DC_DCM_BIT  = 15;
  localparam int MAIN_DC_CCM_BIT  = 14;
  localparam int MAIN_PS_SRC_BIT  = 13;
  localparam int MAIN_PS_REQ_MSB  = 12;
  localparam int MAIN_PS_REQ_LSB  = 11;
  localparam int MAIN_TON_RED_BIT = 9;
  localparam int MAIN_PS_IGN_BIT  = 8;
  localparam int MAIN_CB_BIT      = 7;
  localparam int MAIN_OSR_BIT     = 6;
  localparam int MAIN_APS_BIT     = 5;
  localparam int MAIN_VSRC_BIT    = 4;
  localparam int MAIN_PCNT_MSB    = 2;

  // Aux config field positions
  localparam int AUX_LOW_PWR_BIT  = 3;
  localparam int AUX_SD_STYLE_BIT = 2;
  localparam int AUX_DLY_SEL_BIT  = 1;
  localparam int AUX_SLEW_BIT     = 0;

  // Thermal config field positions
  localparam int THERM_EN_BIT     = 15;
  localparam int SNS_MODE_BIT     = 14;
  localparam int SNS_HYS_MSB      = 13;
  localparam int SNS_HYS_LSB      = 8;
  localparam int TMP_THR_LSB      = 8;
  localparam int TMP_MODE_BIT     = 7;
  localparam int TMP_HYS_MSB      = 6;

  // Phase count codes
  localparam logic [2:0] PCNT_1P_DCM  = 3'h0;
  localparam logic [2:0] PCNT_1P_CCM  = 3'h1;
  localparam logic [2:0] PCNT_4P      = 3'h4;

  // Delay timebase
  localparam int CLK_FREQ_MHZ  = 10;
  localparam int DLY_SHORT_US  = 20;
  localparam int DLY_LONG_US   = 50;
  localparam int DLY_SHORT_CYC = DLY_SHORT_US * CLK_FREQ_MHZ;
  localparam int DLY_LONG_CYC  = DLY_LONG_US * CLK_FREQ_MHZ;
  localparam int DLY_CNT_W     = 9;

  // Power state request decoding
  typedef enum logic [2:0] {
    PM_FULL_CCM = 3'b001,
    PM_1P_CCM   = 3'b010,
    PM_1P_DCM   = 3'b100
  } pccr_pmode_e;

  // Over-temperature protection state
  typedef enum logic [2:0] {
    OT_NORMAL  = 3'b001,
    OT_HICCUP  = 3'b010,
    OT_LATCHED = 3'b100
  } pccr_ot_e;

  // Loop and mode controls seen by the regulator core
  typedef struct packed {
    logic        dc_loop_enable_discontinuous;
    logic        dc_loop_enable_continuous;
    logic        current_balance_enable;
    logic        overshoot_reduce_enable;
    logic        phase_shedding_enable;
    logic        voltage_from_link;
    logic        on_time_reduce_active;
    logic [2:0]  phase_count;
    logic        phase_count_invalid;
    pccr_pmode_e power_mode;
  } pccr_loop_s;

  // Shedding thresholds scaled to amps
  typedef struct packed {
    logic [8:0] single_phase_drop_threshold;
    logic [8:0] discontinuous_drop_threshold;
    logic [8:0] three_phase_drop_threshold;
    logic [8:0] two_phase_drop_threshold;
    logic [8:0] shedding_hysteresis_value;
  } pccr_shed_s;

endpackage : pccr_pkg

/* pccr_config_regs_monitor.sv */
// Assertion checker for the phase control configuration register bank
`timescale 1ns/1ps

module pccr_config_regs_monitor (
  input wire logic                 core_clk,
  input wire logic                 rst_b,
  input wire logic                 cmd_valid,
  input wire logic                 cmd_write,
  input wire logic [7:0]           cmd_code,
  input wire logic [15:0]          cmd_wdata,
  input wire logic                 cmd_ack,
  input wire logic                 cmd_nack,
  input wire logic                 cmd_rvalid,
  input wire logic [15:0]          cmd_rdata,
  input wire logic                 enable_in,
  input wire logic                 total_current_scale,
  input wire pccr_pkg::pccr_loop_s loop_ctrl,
  input wire pccr_pkg::pccr_shed_s shed_amps,
  input wire logic                 low_power_active,
  input wire logic                 pwm_tristate,
  input wire logic                 soft_shutdown,
  input wire logic                 delay_tick,
  input wire logic                 sensor_overheat,
  input wire logic                 temp_overheat,
  input wire logic                 thermal_alert_n
);
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  logic       taken, seen_tick;
  logic [9:0] tick_gap;

  // Request accepted in this cycle
  assign taken = cmd_valid && cmd_ack;

  // Cycles since the last delay tick, saturating
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_gap  <= 10'h000;
      seen_tick <= 1'b0;
    end
    else if (delay_tick)
    begin
      tick_gap  <= 10'h001;
      seen_tick <= 1'b1;
    end
    else if (tick_gap != 10'h3FF)
      tick_gap <= tick_gap + 10'h001;
  end

  // Command port answers and read data
  chk_unmapped_nack: assert property (cmd_valid && (cmd_code < 8'hDF || cmd_code > 8'hEA) |-> cmd_nack && !cmd_ack)
    else $error("unmapped code not refused");
  chk_read_latency: assert property (cmd_rvalid == $past(taken && !cmd_write))
    else $error("read data strobe misplaced");
  chk_spare_trim_zero: assert property (taken && !cmd_write && cmd_code inside {8'hDF, 8'hE0} |=> cmd_rdata == 16'h0000)
    else $error("spare trim not zero");
  chk_spare_shed_ones: assert property (taken && !cmd_write && cmd_code inside {[8'hE5:8'hE7]} |=> cmd_rdata == 16'hFFFF)
    else $error("spare shedding not all ones");

  // Decoded controls follow the stored fields
  chk_main_fields: assert property (taken && cmd_write && cmd_code == 8'hE1 |-> ##2
    {loop_ctrl.dc_loop_enable_discontinuous, loop_ctrl.dc_loop_enable_continuous, loop_ctrl.current_balance_enable,
     loop_ctrl.overshoot_reduce_enable, loop_ctrl.phase_shedding_enable, loop_ctrl.voltage_from_link,
     loop_ctrl.phase_count} == {$past(cmd_wdata[15:14], 2), $past(cmd_wdata[7:4], 2), $past(cmd_wdata[2:0], 2)})
    else $error("main fields not applied");
  chk_pcount_invalid: assert property (loop_ctrl.phase_count_invalid == (loop_ctrl.phase_count > 3'h4))
    else $error("phase count flag wrong");
  chk_shed_scale: assert property (taken && cmd_write && cmd_code == 8'hE3 |-> ##2
    shed_amps.single_phase_drop_threshold == ($past(total_current_scale) ? {$past(cmd_wdata[15:8], 2), 1'b0}
                                                                         : {1'b0, $past(cmd_wdata[15:8], 2)}))
    else $error("shedding scale wrong");

  // Low power, shutdown style, timebase and alert
  chk_low_power_nack: assert property (cmd_valid && low_power_active |-> cmd_nack && !cmd_ack)
    else $error("request accepted in low power");
  chk_low_power_pin: assert property (low_power_active |-> !enable_in)
    else $error("low power while enabled");
  chk_low_power_tristate: assert property (low_power_active |=> pwm_tristate && !soft_shutdown)
    else $error("low power without tri-state");
  chk_enable_release: assert property (enable_in |=> !pwm_tristate && !soft_shutdown)
    else $error("shutdown while enabled");
  chk_tick_spacing: assert property (delay_tick && seen_tick |-> tick_gap >= 10'h0C8)
    else $error("delay ticks too close");
  chk_alert_pin: assert property (thermal_alert_n == !(sensor_overheat || temp_overheat))
    else $error("alert pin disagrees");

  cover property (taken && cmd_write && cmd_code == 8'hE1);
  cover property (cmd_valid && low_power_active);
  cover property (sensor_overheat && temp_overheat == 1'b0);
endmodule : pccr_config_regs_monitor

bind pccr_config_regs pccr_config_regs_monitor mon_u (.*);

/* pccr_host_model.sv */
// Host model that issues commands on the register command port
`timescale 1ns/1ps

module pccr_host_model (
  input  wire logic        core_clk,
  input  wire logic        cmd_ack,
  input  wire logic        cmd_nack,
  input  wire logic        cmd_rvalid,
  input  wire logic [15:0] cmd_rdata,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata
);
  // Idle request lines at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // One request held until answered or for at most 8 edges; read data taken one edge later
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [1:0] resp, output logic [15:0] rd);
    resp = 2'b00;
    rd = 16'hXXXX;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code  <= c;
    cmd_wdata <= d;
    for (int i = 0; i < 8 && resp == 2'b00; i++)
    begin
      @(posedge core_clk);
      resp = {cmd_ack, cmd_nack};
    end
    // Released lines stop showing the last value
    cmd_valid <= 1'b0;
    cmd_code  <= ~c;
    cmd_wdata <= ~d;
    if (!w && resp == 2'b10)
    begin
      @(posedge core_clk);
      if (cmd_rvalid === 1'b1)
        rd = cmd_rdata;
    end
  endtask : xfer
endmodule : pccr_host_model

/* pccr_config_regs_tb.sv */
// Self-checking testbench for the phase control configuration register bank
`timescale 1ns/1ps

module pccr_config_regs_tb;
  logic                 core_clk, rst_b, cmd_valid, cmd_write, cmd_ack, cmd_nack, cmd_rvalid, enable_in;
  logic                 total_current_scale, fault_clear, low_power_active, pwm_tristate, soft_shutdown;
  logic                 rc_slew_active, delay_tick, sensor_overheat, temp_overheat, thermal_alert_n;
  logic [7:0]           cmd_code, temp_sensor_pin, temperature_input, code;
  logic [15:0]          cmd_wdata, cmd_rdata, rd, cfg, mdl [256];
  logic [1:0]           power_state_input, resp;
  pccr_pkg::pccr_loop_s loop_ctrl;
  pccr_pkg::pccr_shed_s shed_amps;
  logic [15:0]          aux_set [4] = '{16'h0008, 16'h000C, 16'h0004, 16'h0000};
  int                   bad_count, n_tests, gap;

  pccr_config_regs dut_u (.*);
  pccr_host_model host_u (.*);

  // Free-running clock
  always #50 core_clk = ~core_clk;

  // Compare and count
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic fail_wait();
    bad_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    final_report();
  endtask : fail_wait

  // Command access through the host model
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
    host_u.xfer(w, c, d, resp, rd);
    if (resp == 2'b00)
      fail_wait();
  endtask : cmd

  function automatic logic [15:0] wmask(input logic [7:0] c);
    case (c)
      8'hE1: wmask = 16'hFBF7;
      8'hE2: wmask = 16'h000F;
      8'hE8: wmask = 16'h00FF;
      8'hE3, 8'hE4, 8'hE9, 8'hEA: wmask = 16'hFFFF;
      default: wmask = 16'h0000;
    endcase
  endfunction : wmask

  task automatic put(input logic [7:0] c, input logic [15:0] d);
    cmd(1'b1, c, d);
    if (resp == 2'b10)
      mdl[c] = d & wmask(c);
  endtask : put

  function automatic logic [15:0] exp_rd(input logic [7:0] c);
    exp_rd = (c >= 8'hE5 && c <= 8'hE7) ? 16'hFFFF : mdl[c];
  endfunction : exp_rd

  function automatic logic [2:0] exp_mode(input logic [15:0] m, input logic [1:0] pin);
    logic [1:0] req;
    req = m[13] ? m[12:11] : pin;
    if (m[8] && m[5])
      exp_mode = 3'b001;
    else
      exp_mode = req[1] ? 3'b100 : (req[0] ? 3'b010 : 3'b001);
  endfunction : exp_mode

  function automatic logic [8:0] sc(input logic [7:0] v);
    sc = total_current_scale ? {v, 1'b0} : {1'b0, v};
  endfunction : sc

  // Counts edges up to the next delay tick
  task automatic wait_tick();
    gap = 0;
    do
    begin
      @(posedge core_clk);
      gap++;
    end
    while (delay_tick !== 1'b1 && gap < 600);
    if (gap == 600)
      fail_wait();
  endtask : wait_tick

  task automatic drive(input logic [7:0] c, input logic [7:0] v, input logic en, input logic clr);
    @(posedge core_clk);
    if (c == 8'hE9)
      temp_sensor_pin <= v;
    else
      temperature_input <= v;
    enable_in <= en;
    fault_clear <= clr;
    repeat (3) @(posedge core_clk);
  endtask : drive

  // Main sequence
  initial
  begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    power_state_input = 2'h0;
    enable_in = 1'b1;
    total_current_scale = 1'b0;
    temp_sensor_pin = 8'h00;
    temperature_input = 8'h00;
    fault_clear = 1'b0;
    bad_count = 0;
    n_tests = 0;
    foreach (mdl[i]) mdl[i] = 16'h0000;
    void'($urandom(32));
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int c = 8'hDF; c <= 8'hEA; c++)
    begin
      cmd(1'b0, 8'(c), 16'h0000);
      check(rd, exp_rd(8'(c)));
    end
    for (int k = 0; k < 4; k++)
    begin
      cmd(k[0], k[1] ? 8'hEB : 8'hDE, 16'hFFFF);
      check(resp, 2'b01);
    end
    $display("test reset_and_refusal done");
    for (int k = 0; k < 80; k++)
    begin
      @(posedge core_clk);
      power_state_input <= 2'($urandom);
      total_current_scale <= 1'($urandom);
      code = 8'hDF + 8'($urandom_range(11));
      cfg = 16'($urandom);
      if (code == 8'hE1)
        cfg = {cfg[15:4], 1'b0, (cfg[2:0] > 3'h4) ? 3'h4 : cfg[2:0]};
      else if (code == 8'hE2)
        cfg[5:4] = 2'b00;
      put(code, cfg);
      code = 8'hDF + 8'($urandom_range(11));
      cmd(1'b0, code, 16'h0000);
      check(rd, exp_rd(code));
      cfg = mdl[8'hE1];
      check(loop_ctrl.power_mode, exp_mode(cfg, power_state_input));
      check(loop_ctrl.on_time_reduce_active, cfg[9] && (cfg[2:0] == 3'h0
            || exp_mode(cfg, power_state_input) == 3'b100));
      check(rc_slew_active, mdl[8'hE2][0] && !cfg[4]);
      check(shed_amps, {sc(mdl[8'hE3][15:8]), sc(mdl[8'hE3][7:0]), sc(mdl[8'hE4][15:8]),
            sc(mdl[8'hE4][7:0]), sc(mdl[8'hE8][7:0])});
    end
    $display("test random_registers done");
    for (int k = 0; k < 4; k++)
    begin
      put(8'hE2, aux_set[k]);
      drive(8'hE9, 8'h00, 1'b0, 1'b0);
      check(low_power_active, aux_set[k][3]);
      check({pwm_tristate, soft_shutdown}, (aux_set[k][3] || !aux_set[k][2]) ? 2'b10 : 2'b01);
      cmd(1'b0, 8'hE1, 16'h0000);
      check(resp, aux_set[k][3] ? 2'b01 : 2'b10);
      drive(8'hE9, 8'h00, 1'b1, 1'b0);
      check({pwm_tristate, soft_shutdown}, 2'b00);
    end
    $display("test shutdown done");
    for (int k = 0; k < 2; k++)
    begin
      put(8'hE2, {14'h0000, k[0], 1'b0});
      wait_tick();
      wait_tick();
      check(gap, k ? 50 * 10 : 20 * 10);
    end
    $display("test delay_timebase done");
    put(8'hE9, 16'h0000);
    put(8'hEA, 16'hFF00);
    for (int k = 0; k < 4; k++)
    begin
      code = k[1] ? 8'hEA : 8'hE9;
      cfg = k[1] ? {8'h80, k[0], 7'h04} : {1'b1, k[0], 6'h04, 8'h80};
      put(code, cfg);
      drive(code, 8'h00, 1'b1, 1'b1);
      drive(code, 8'h80, 1'b1, 1'b0);
      check({sensor_overheat, temp_overheat, thermal_alert_n}, {!k[1], k[1], 1'b0});
      drive(code, 8'h7D, 1'b1, 1'b0);
      check({sensor_overheat, temp_overheat}, {!k[1], k[1]});
      drive(code, 8'h7C, 1'b1, 1'b0);
      check({sensor_overheat, temp_overheat}, {!k[1] && k[0], k[1] && k[0]});
      drive(code, 8'h7C, 1'b1, 1'b1);
      drive(code, 8'h00, 1'b1, 1'b0);
      check({sensor_overheat, temp_overheat, thermal_alert_n}, 3'b001);
      put(code, k[1] ? 16'hFF00 : 16'h0000);
    end
    $display("test overheat done");
    final_report();
  end
endmodule : pccr_config_regs_tb
